/* design/sdp_serial_dac_port.sv */
// serial word input port, converter latch and register slave
`timescale 1ns/1ps
`default_nettype none
module sdp_serial_dac_port
    import sdp_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // serial pins
    input  wire logic                  serial_clk,
    input  wire logic                  frame_sync_n,
    input  wire logic                  serial_word_in,
    input  wire logic                  latch_load_strobe_n,
    input  wire logic                  chain_enable,
    input  wire logic                  clear_n,
    input  wire logic                  code_format_select,
    output var  logic                  chain_data_out,
    output var  logic                  chain_data_out_en,
    // offset-binary code to the analog stage
    output var  logic [11:0]           converter_code,
    // axi4-lite slave
    input  wire logic [SDP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [SDP_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [SDP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [SDP_DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    function automatic logic [3:0] sdp_word_addr(input logic [SDP_ADDR_W-1:0] a);
        sdp_word_addr = {a[3:2], 2'h0};
    endfunction : sdp_word_addr

    logic [SDP_PIN_COUNT-1:0] pins_s, pins_prev;
    logic [15:0]              shift;
    logic [4:0]               bit_count;
    logic [11:0]              latch;
    logic                     auto_mode, soft_clear, wr_strb0;
    sdp_frame_e               state;
    logic [SDP_ADDR_W-1:0]    wr_addr;
    logic [SDP_DATA_W-1:0]    wr_data;
    sdp_sync2 #(.WIDTH(SDP_PIN_COUNT)) u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in ({code_format_select, clear_n, chain_enable, latch_load_strobe_n,
                    serial_word_in, frame_sync_n, serial_clk}),
        .sync_out (pins_s)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pins_prev <= '0;
        end else begin
            pins_prev <= pins_s;
        end
    end

    logic        sclk_fall, sync_fall, load_fall, sync_low;
    logic        din_s, chain_s, fmt_s, clear_level;
    logic        auto_eff, accept, auto_fire;
    logic [4:0]  cnt_base;
    logic [15:0] shift_next;

    always_comb begin
        sclk_fall   = pins_prev[SDP_PIN_SCLK] & ~pins_s[SDP_PIN_SCLK];
        sync_fall   = pins_prev[SDP_PIN_SYNC] & ~pins_s[SDP_PIN_SYNC];
        load_fall   = pins_prev[SDP_PIN_LOAD] & ~pins_s[SDP_PIN_LOAD];
        sync_low    = ~pins_s[SDP_PIN_SYNC];
        din_s       = pins_s[SDP_PIN_DIN];
        chain_s     = pins_s[SDP_PIN_CHAIN];
        fmt_s       = pins_s[SDP_PIN_FMT];
        clear_level = ~pins_s[SDP_PIN_CLR] | soft_clear;
        // a frame start and its first edge may land in one cycle
        cnt_base    = sync_fall ? SDP_CNT_ZERO : bit_count;
        auto_eff    = sync_fall ? ~pins_s[SDP_PIN_LOAD] : auto_mode;
        accept      = sclk_fall & sync_low & (sync_fall | (state != SDP_ST_IDLE))
                    & (chain_s | (cnt_base != SDP_WORD_CNT));
        auto_fire   = accept & auto_eff & (cnt_base == SDP_LAST_CNT);
        shift_next  = {shift[SDP_SHIFT_MSB-1:0], din_s};
    end
    // frame state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= SDP_ST_IDLE;
        end else begin
            case (state)
                SDP_ST_IDLE: begin
                    if (sync_fall) begin
                        state <= SDP_ST_SHIFT;
                    end
                end
                SDP_ST_SHIFT: begin
                    if (!sync_low) begin
                        state <= SDP_ST_IDLE;
                    end else if (accept && !chain_s && cnt_base == SDP_LAST_CNT) begin
                        state <= SDP_ST_DONE;
                    end
                end
                SDP_ST_DONE: begin
                    if (!sync_low) begin
                        state <= SDP_ST_IDLE;
                    end else if (sync_fall) begin
                        state <= SDP_ST_SHIFT;
                    end
                end
                default: state <= SDP_ST_IDLE;
            endcase
        end
    end
    // bit counter, saturates so chain mode cannot wrap it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_count <= SDP_CNT_ZERO;
            auto_mode <= 1'b0;
        end else begin
            if (sync_fall) begin
                auto_mode <= ~pins_s[SDP_PIN_LOAD];
            end
            if (accept && cnt_base != SDP_WORD_CNT) begin
                bit_count <= 5'(cnt_base + SDP_CNT_ONE);
            end else begin
                bit_count <= cnt_base;
            end
        end
    end
    // shift register and chain output
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift             <= '0;
            chain_data_out    <= 1'b0;
            chain_data_out_en <= 1'b0;
        end else begin
            chain_data_out_en <= chain_s;
            if (accept) begin
                shift <= shift_next;
                if (chain_s) begin
                    chain_data_out <= shift[SDP_SHIFT_MSB];
                end
            end
        end
    end
    // converter latch, clear wins over any load
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latch <= SDP_CODE_CLEAR;
        end else if (clear_level) begin
            latch <= SDP_CODE_CLEAR;
        end else if (auto_fire) begin
            latch <= shift_next[SDP_CODE_BITS-1:0];
        end else if (load_fall && !auto_mode) begin
            latch <= shift[SDP_CODE_BITS-1:0];
        end
    end
    // two's complement flips the msb so zero lands at midscale
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            converter_code <= SDP_CODE_CLEAR;
        end else begin
            converter_code <= fmt_s ? (latch ^ SDP_MIDSCALE) : latch;
        end
    end
    // write channel: address and data taken in either order
    logic do_write;
    assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SDP_RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb0      <= 1'b0;
            soft_clear    <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb0     <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bvalid  <= 1'b1;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                case (sdp_word_addr(wr_addr))
                    SDP_OFF_CTRL: begin
                        s_axi_bresp <= SDP_RESP_OKAY;
                        if (wr_strb0) begin
                            soft_clear <= wr_data[SDP_CTRL_CLR_BIT];
                        end
                    end
                    SDP_OFF_STATUS, SDP_OFF_SHIFT: s_axi_bresp <= SDP_RESP_OKAY;
                    default: s_axi_bresp <= SDP_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // read channel, one cycle to data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= SDP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= SDP_RESP_OKAY;
            case (sdp_word_addr(s_axi_araddr))
                SDP_OFF_CTRL: s_axi_rdata[SDP_CTRL_CLR_BIT] <= soft_clear;
                SDP_OFF_STATUS: begin
                    s_axi_rdata[SDP_CODE_BITS-1:0]  <= latch;
                    s_axi_rdata[SDP_STAT_AUTO_BIT]  <= auto_mode;
                    s_axi_rdata[SDP_STAT_DONE_BIT]  <= (state == SDP_ST_DONE);
                    s_axi_rdata[SDP_STAT_CHAIN_BIT] <= chain_s;
                    s_axi_rdata[SDP_STAT_FMT_BIT]   <= fmt_s;
                    s_axi_rdata[SDP_STAT_CNT_LSB +: SDP_CNT_W] <= bit_count;
                end
                SDP_OFF_SHIFT: s_axi_rdata[SDP_WORD_BITS-1:0] <= shift;
                default: s_axi_rresp <= SDP_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    sequence s_deferred_load;
        load_fall && !auto_mode && !clear_level && !auto_fire;
    endsequence

    a_shift_on_fall: assert property (@(posedge clock) disable iff (!reset_n)
        accept |=> shift == {$past(shift[14:0]), $past(din_s)})
        else $error("shift register missed a falling serial clock edge");
    a_frame_count_reset: assert property (@(posedge clock) disable iff (!reset_n)
        (sync_fall && !sclk_fall) |=> bit_count == SDP_CNT_ZERO)
        else $error("frame start did not clear the bit counter");
    a_deferred_load: assert property (@(posedge clock) disable iff (!reset_n)
        s_deferred_load |=> latch == $past(shift[11:0]))
        else $error("strobe fall did not load the latch");
    a_auto_update: assert property (@(posedge clock) disable iff (!reset_n)
        (auto_fire && !clear_level) |=> latch == $past(shift_next[11:0]))
        else $error("automatic update missed the sixteenth edge");
    a_chain_out_en: assert property (@(posedge clock) disable iff (!reset_n)
        1'b1 |=> chain_data_out_en == $past(chain_s))
        else $error("chain output enable does not follow chain mode");
    a_chain_out_bit: assert property (@(posedge clock) disable iff (!reset_n)
        (accept && chain_s) |=> chain_data_out == $past(shift[15]))
        else $error("chain output did not carry the bit shifted out");
    a_clear_zero: assert property (@(posedge clock) disable iff (!reset_n)
        clear_level |=> latch == SDP_CODE_CLEAR ##1 converter_code ==
            ($past(fmt_s) ? SDP_MIDSCALE : SDP_CODE_CLEAR))
        else $error("clear did not drive the latch and output code");
    a_midscale_map: assert property (@(posedge clock) disable iff (!reset_n)
        (latch == SDP_CODE_CLEAR && fmt_s) |=> converter_code == SDP_MIDSCALE)
        else $error("two's complement zero is not midscale");
    a_word_gate: assert property (@(posedge clock) disable iff (!reset_n)
        (!chain_s && bit_count == SDP_WORD_CNT && !sync_fall) |=> $stable(shift))
        else $error("standalone frame took more than sixteen bits");
    a_mode_pick: assert property (@(posedge clock) disable iff (!reset_n)
        sync_fall |=> auto_mode == !$past(pins_s[SDP_PIN_LOAD]))
        else $error("update mode not taken at frame start");
endmodule : sdp_serial_dac_port
`default_nettype wire

/* shared/sdp_pkg.sv */
// constants, pin indices and register map of the serial converter input port
`default_nettype none
package sdp_pkg;
    // serial word and converter latch
    localparam int         SDP_WORD_BITS  = 16;
    localparam int         SDP_CODE_BITS  = 12;
    localparam int         SDP_CNT_W      = 5;
    localparam logic [4:0] SDP_WORD_CNT   = 5'h10;
    localparam logic [4:0] SDP_LAST_CNT   = 5'h0F;
    localparam logic [4:0] SDP_CNT_ZERO   = 5'h00;
    localparam logic [4:0] SDP_CNT_ONE    = 5'h01;
    localparam int         SDP_SHIFT_MSB  = 15;
    localparam logic [11:0] SDP_CODE_CLEAR = 12'h000;
    localparam logic [11:0] SDP_MIDSCALE   = 12'h800;

    // pin positions inside the synchroniser vector
    localparam int SDP_PIN_COUNT = 7;
    localparam int SDP_PIN_SCLK  = 0;
    localparam int SDP_PIN_SYNC  = 1;
    localparam int SDP_PIN_DIN   = 2;
    localparam int SDP_PIN_LOAD  = 3;
    localparam int SDP_PIN_CHAIN = 4;
    localparam int SDP_PIN_CLR   = 5;
    localparam int SDP_PIN_FMT   = 6;

    // register bus
    localparam int          SDP_ADDR_W      = 4;
    localparam int          SDP_DATA_W      = 32;
    localparam logic [3:0]  SDP_OFF_CTRL    = 4'h0;
    localparam logic [3:0]  SDP_OFF_STATUS  = 4'h4;
    localparam logic [3:0]  SDP_OFF_SHIFT   = 4'h8;
    localparam logic [1:0]  SDP_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SDP_RESP_SLVERR = 2'h2;
    localparam int          SDP_CTRL_CLR_BIT   = 0;
    localparam int          SDP_STAT_AUTO_BIT  = 16;
    localparam int          SDP_STAT_DONE_BIT  = 17;
    localparam int          SDP_STAT_CHAIN_BIT = 18;
    localparam int          SDP_STAT_FMT_BIT   = 19;
    localparam int          SDP_STAT_CNT_LSB   = 20;

    // frame state, gray along idle -> shift -> done
    typedef enum logic [1:0] {
        SDP_ST_IDLE  = 2'h0,
        SDP_ST_SHIFT = 2'h1,
        SDP_ST_DONE  = 2'h3
    } sdp_frame_e;
endpackage : sdp_pkg
`default_nettype wire

/* design/sdp_sync2.sv */
// two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sdp_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : sdp_sync2
`default_nettype wire

/* test/sdp_host_model.sv */
// host serial port model driving the converter input pins
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model (
    // alignment clock
    input  wire logic clock,
    // serial pins toward the port
    output var  logic serial_clk,
    output var  logic frame_sync_n,
    output var  logic serial_word_in,
    output var  logic latch_load_strobe_n
);
    // half of the 64 ns link period, counted in 4 ns system clocks
    localparam int HALF = 8;

    initial begin
        serial_clk = 1'b1;
        frame_sync_n = 1'b1;
        serial_word_in = 1'b0;
        latch_load_strobe_n = 1'b1;
    end

    // link clock idles high outside frames; data shows inverse once released
    task automatic frame(input logic [31:0] bits, input int n);
        @(posedge clock);
        frame_sync_n <= 1'b0;
        repeat (HALF) @(posedge clock);
        for (int i = n - 1; i >= 0; i--) begin
            serial_word_in <= bits[i];
            repeat (HALF) @(posedge clock);
            serial_clk <= 1'b0;
            repeat (HALF) @(posedge clock);
            serial_clk <= 1'b1;
        end
        repeat (HALF) @(posedge clock);
        frame_sync_n <= 1'b1;
        serial_word_in <= ~serial_word_in;
        repeat (HALF) @(posedge clock);
    endtask : frame

    // strobe level at sync fall picks the update mode
    task automatic strobe(input logic level);
        @(posedge clock);
        latch_load_strobe_n <= level;
        repeat (2 * HALF) @(posedge clock);
    endtask : strobe
endmodule : sdp_host_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the serial converter input port
`timescale 1ns/1ps
`default_nettype none
module tb
    import sdp_pkg::*;
;
    logic clock, reset_n, chain_enable, clear_n, code_format_select;
    logic serial_clk, frame_sync_n, serial_word_in, latch_load_strobe_n;
    logic chain_data_out, chain_data_out_en, sclk_q;
    logic [11:0] converter_code, prev;
    logic [15:0] out_sr;
    logic [SDP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [SDP_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    typedef struct packed {
        logic        fmt;
        logic        auto_up;
        logic [15:0] word;
        logic [11:0] code;
    } sdp_row_s;
    // expected code is the offset-binary value the analog stage sees
    sdp_row_s rows [5] = '{
        '{1'b0, 1'b1, 16'hF123, 12'h123},
        '{1'b1, 1'b0, 16'h0000, 12'h800},
        '{1'b0, 1'b0, 16'h5800, 12'h800},
        '{1'b1, 1'b1, 16'hA7FF, 12'hFFF},
        '{1'b0, 1'b1, 16'h0ABC, 12'hABC}
    };

    sdp_serial_dac_port sdp_serial_dac_port_i (
        .clock, .reset_n, .serial_clk, .frame_sync_n, .serial_word_in,
        .latch_load_strobe_n, .chain_enable, .clear_n, .code_format_select,
        .chain_data_out, .chain_data_out_en, .converter_code,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    sdp_host_model sdp_host_model_i (
        .clock, .serial_clk, .frame_sync_n, .serial_word_in, .latch_load_strobe_n
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // chain output is read at link clock rises, long after it settled
    always @(posedge clock) begin
        cycles <= cycles + 1;
        sclk_q <= serial_clk;
        if (serial_clk && !sclk_q && !frame_sync_n) begin
            out_sr <= {out_sr[14:0], chain_data_out};
        end
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic note(input string s);
        $display("test %s finished", s);
    endtask : note

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge clock);
        check(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] ed,
                          input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        check(s_axi_rdata & m, ed);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : axi_rd

    initial begin
        reset_n = 1'b0;
        chain_enable = 1'b0;
        clear_n = 1'b1;
        code_format_select = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        check(converter_code, 12'h000);
        check(chain_data_out_en, 1'b0);
        axi_rd(SDP_OFF_CTRL, '1, 32'h0, SDP_RESP_OKAY);
        note("reset");
        prev = 12'h000;
        foreach (rows[k]) begin
            @(posedge clock);
            code_format_select <= rows[k].fmt;
            sdp_host_model_i.strobe(!rows[k].auto_up);
            sdp_host_model_i.frame({16'h0, rows[k].word}, 16);
            if (!rows[k].auto_up) begin
                check(converter_code, prev ^ {rows[k].fmt, 11'h0});
                sdp_host_model_i.strobe(1'b0);
            end
            check(converter_code, rows[k].code);
            prev = rows[k].code ^ {rows[k].fmt, 11'h0};
        end
        note("table");
        // short frame then an over-long one: the count must restart
        sdp_host_model_i.frame(32'h1F, 5);
        check(converter_code, 12'hABC);
        sdp_host_model_i.frame(32'hABCDE, 20);
        check(converter_code, 12'hBCD);
        @(posedge clock);
        axi_rd(SDP_OFF_SHIFT, '1, 32'hABCD, SDP_RESP_OKAY);
        axi_rd(SDP_OFF_STATUS, ~32'h20000, 32'h0101_0BCD, SDP_RESP_OKAY);
        axi_rd(4'hC, '1, 32'h0, SDP_RESP_SLVERR);
        axi_wr(4'hC, 32'h1, SDP_RESP_SLVERR);
        axi_wr(SDP_OFF_SHIFT, 32'hFFFF, SDP_RESP_OKAY);
        axi_rd(SDP_OFF_SHIFT, '1, 32'hABCD, SDP_RESP_OKAY);
        note("count");
        clear_n <= 1'b0;
        repeat (6) @(posedge clock);
        check(converter_code, 12'h000);
        code_format_select <= 1'b1;
        repeat (6) @(posedge clock);
        check(converter_code, 12'h800);
        sdp_host_model_i.frame(32'h0555, 16);
        check(converter_code, 12'h800);
        @(posedge clock);
        clear_n <= 1'b1;
        sdp_host_model_i.frame(32'h0321, 16);
        check(converter_code, 12'hB21);
        @(posedge clock);
        axi_wr(SDP_OFF_CTRL, 32'h1, SDP_RESP_OKAY);
        repeat (4) @(posedge clock);
        check(converter_code, 12'h800);
        axi_rd(SDP_OFF_CTRL, 32'h1, 32'h1, SDP_RESP_OKAY);
        axi_wr(SDP_OFF_CTRL, 32'h0, SDP_RESP_OKAY);
        note("clear");
        code_format_select <= 1'b0;
        chain_enable <= 1'b1;
        sdp_host_model_i.strobe(1'b1);
        check(chain_data_out_en, 1'b1);
        sdp_host_model_i.frame(32'h1235_5678, 32);
        check(out_sr, 16'h1235);
        check(converter_code, 12'h000);
        sdp_host_model_i.strobe(1'b0);
        check(converter_code, 12'h678);
        note("chain");
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        check(converter_code, 12'h000);
        check(chain_data_out_en, 1'b0);
        reset_n <= 1'b1;
        axi_rd(SDP_OFF_SHIFT, '1, 32'h0, SDP_RESP_OKAY);
        check(converter_code, 12'h000);
        note("second reset");
        conclude();
    end
endmodule : tb
`default_nettype wire
